//--- design/rie_exc_ctrl.sv
// Reset and interrupt exception controller with APB register access.
// Assumes all pins synchronous to pclk; the core reports instruction
// and exception-sequence ends as one-cycle pulses.
//
// Summary of operation
// - Clear pin low forces reset state at once
// - Accept only at instruction or sequence end
// - Reset state initialises core and modules
// - Latch mode pins when clear releases
// - Reset exit sets mask, inits modules
// - Reset sequence fetches vector at 0000
// - No interrupt before first instruction ends
// - NMI after first instruction; external lines need enable
// - Mask bit blocks all but nonmaskable
// - Lines sense rise, fall or low level
// - NMI edge chosen by edge-select bit
// - Each source has its own vector
// - Seventeen internal requests, numbers 7 to 23
// - Fixed priority by ascending vector number
// - Table words 0002 to 0005 unused
// - Only edge-select bit of system control used
// - Sense bits decode level, fall, rise
// - Per-line enable bits, reset zero
// - Edge requests latched until served
// - Acceptance sets the mask bit
`timescale 1ns/10ps
module rie_exc_ctrl
  import rie_pkg::*;
(
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset
  input wire logic clk_en, // Freezes state when low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic chip_clear_pin_n, // Chip clear pin
  input wire logic mode_select_pin_hi, // Mode pin 1
  input wire logic mode_select_pin_lo, // Mode pin 0
  input wire logic nmi_pin_n, // Nonmaskable pin
  input wire logic ext_line_0_n, // External line 0
  input wire logic ext_line_1_n, // External line 1
  input wire logic ext_line_2_n, // External line 2
  input wire logic [NUM_INT-1:0] int_req, // Internal flags, bit 0 first
  input wire logic instr_done, // Instruction end pulse
  input wire logic seq_done, // Exception sequence end pulse
  input wire logic ccr_i_wr, // Core writes mask bit
  input wire logic ccr_i_wdata, // Value of mask write
  output logic ccr_i_mask, // Mask bit of the CONDITION_CODE_REG
  output logic core_hold, // Core abandons work
  output logic periph_init, // Modules initialise
  output logic exc_start, // Sequence start pulse
  output logic exc_is_reset, // Start is a reset
  output logic [15:0] exc_vec_addr, // Vector table address
  output logic latched_mode_bit_hi, // Mode bit 1
  output logic latched_mode_bit_lo // Mode bit 0
);
  rie_state_t st_reg, st_next;
  logic after_rst_reg, after_rst_next;
  logic start_reg, start_next;
  logic isrst_reg, isrst_next;
  logic [15:0] vec_reg, vec_next;
  logic imask_reg, imask_next;
  logic [NUM_SRC-1:0] serve;

  logic [7:0] system_control_reg, system_control_next;
  logic [7:0] line_sense_select_reg, ext_line_sense_select_next;
  logic [7:0] line_enable_reg, ier_next;
  logic [1:0] mode_reg, mode_next;
  logic short_reg, short_next;
  logic [3:0] low_cnt_reg, low_cnt_next;
  logic [31:0] rdata_reg, rdata_next;
  logic err_reg, err_next;

  logic clear_n;
  logic in_clear;
  logic [NUM_EXT-1:0] ext_pin_n;
  logic [NUM_EXT-1:0] ext_req;
  logic nmi_req;
  logic [NUM_SRC-1:0] elig;
  logic win_valid;
  logic [4:0] win_idx;
  logic take;
  logic accept;
  logic wr_acc;
  logic [15:0] idx;
  logic [31:0] stat_word;

  assign clear_n = chip_clear_pin_n;
  assign in_clear = ~clear_n;
  assign ext_pin_n = {ext_line_2_n, ext_line_1_n, ext_line_0_n};

  // NMI is an always-edge line; its polarity is the edge-select bit
  rie_line_sense u_nmi (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .clear(in_clear),
    .pin_n(nmi_pin_n),
    .edge_mode(1'b1),
    .rising(system_control_reg[SYSTEM_CONTROL_NONMASKABLE_EDGE_SELECT]),
    .serve(serve[0]),
    .req(nmi_req)
  );

  for (genvar g = 0; g < NUM_EXT; g++) begin : g_line
    rie_line_sense u_line (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .clear(in_clear),
      .pin_n(ext_pin_n[g]),
      .edge_mode(line_sense_select_reg[EXT_LINE_SENSE_SELECT_SC_LSB + g]),
      .rising(line_sense_select_reg[EXT_LINE_SENSE_SELECT_EG_LSB + g]),
      .serve(serve[g + 1]),
      .req(ext_req[g])
    );
  end

  // Index 0 is vector 3; internal flags follow the external lines
  always_comb begin
    elig[0] = nmi_req;
    elig[NUM_EXT:1] = ext_req & line_enable_reg[NUM_EXT-1:0] & {NUM_EXT{~imask_reg}};
    elig[NUM_SRC-1:NUM_EXT+1] = int_req & {NUM_INT{~imask_reg}};
  end

  rie_prio #(
    .N(NUM_SRC)
  ) u_prio (
    .pend(elig),
    .valid(win_valid),
    .index(win_idx)
  );

  // Boundaries where a pending request may start its sequence
  always_comb begin
    take = 1'b0;
    if (clear_n) begin
      unique case (st_reg)
        ST_FIRST, ST_RUN: take = instr_done;
        ST_SEQ: take = seq_done & ~after_rst_reg;
        default: take = 1'b0;
      endcase
    end
  end

  assign accept = take & win_valid;

  always_comb begin
    serve = '0;
    if (accept) begin
      serve[win_idx] = 1'b1;
    end
  end

  always_comb begin
    st_next = st_reg;
    after_rst_next = after_rst_reg;
    start_next = 1'b0;
    isrst_next = 1'b0;
    vec_next = vec_reg;
    imask_next = imask_reg;
    if (ccr_i_wr) begin
      imask_next = ccr_i_wdata;
    end
    unique case (st_reg)
      ST_CLEAR: begin
        st_next = ST_RSTSEQ;
      end
      ST_RSTSEQ: begin
        start_next = 1'b1;
        isrst_next = 1'b1;
        vec_next = VEC_RESET;
        imask_next = 1'b1;
        after_rst_next = 1'b1;
        st_next = ST_SEQ;
      end
      ST_SEQ: begin
        if (seq_done) begin
          if (after_rst_reg) begin
            after_rst_next = 1'b0;
            st_next = ST_FIRST;
          end else if (!accept) begin
            st_next = ST_RUN;
          end
        end
      end
      ST_FIRST: begin
        if (instr_done) begin
          st_next = ST_RUN;
        end
      end
      ST_RUN: begin
        st_next = ST_RUN;
      end
    endcase
    if (accept) begin
      start_next = 1'b1;
      vec_next = rie_vec_addr(win_idx + VEC_NUM_NMI);
      imask_next = 1'b1;
      st_next = ST_SEQ;
    end
    if (!clear_n) begin
      st_next = ST_CLEAR;
      after_rst_next = 1'b0;
      start_next = 1'b0;
      vec_next = VEC_RESET;
      imask_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= ST_CLEAR;
      after_rst_reg <= 1'b0;
      start_reg <= 1'b0;
      isrst_reg <= 1'b0;
      vec_reg <= VEC_RESET;
      imask_reg <= 1'b1;
    end else if (clk_en) begin
      st_reg <= st_next;
      after_rst_reg <= after_rst_next;
      start_reg <= start_next;
      isrst_reg <= isrst_next;
      vec_reg <= vec_next;
      imask_reg <= imask_next;
    end
  end

  // Mode capture and short-reset watch
  always_comb begin
    mode_next = mode_reg;
    low_cnt_next = low_cnt_reg;
    short_next = short_reg;
    if (st_reg == ST_CLEAR && clear_n) begin
      mode_next = {mode_select_pin_hi, mode_select_pin_lo};
    end
    if (!clear_n) begin
      if (low_cnt_reg != RST_CNT_MAX) begin
        low_cnt_next = low_cnt_reg + 4'h1;
      end
    end else begin
      low_cnt_next = 4'h0;
    end
    if (wr_acc && idx == IDX_STAT && pwdata[STAT_SHORT]) begin
      short_next = 1'b0;
    end
    // A too-short pulse still resets; the flag only tells software
    if (st_reg == ST_CLEAR && clear_n && low_cnt_reg < RST_CNT_MAX) begin
      short_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= 2'b00;
      low_cnt_reg <= RST_CNT_MAX;
      short_reg <= 1'b0;
    end else if (clk_en) begin
      mode_reg <= mode_next;
      low_cnt_reg <= low_cnt_next;
      short_reg <= short_next;
    end
  end

  // Register bus: zero wait states, data latched in the setup phase
  assign idx = paddr[ADDR_W-1:2];
  assign wr_acc = psel & penable & pwrite;

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[STAT_SHORT] = short_reg;
    stat_word[STAT_IMASK] = imask_reg;
    stat_word[STAT_INSEQ] = (st_reg == ST_SEQ);
    stat_word[STAT_VEC_LSB +: 16] = vec_reg;
  end

  always_comb begin
    system_control_next = system_control_reg;
    ext_line_sense_select_next = line_sense_select_reg;
    ier_next = line_enable_reg;
    rdata_next = rdata_reg;
    err_next = err_reg;
    if (wr_acc && paddr[1:0] == 2'b00) begin
      if (idx == IDX_SYSTEM_CONTROL) begin
        system_control_next = (pwdata[7:0] & SYSTEM_CONTROL_WMASK) | (SYSTEM_CONTROL_RST & ~SYSTEM_CONTROL_WMASK);
      end
      if (idx == IDX_EXT_LINE_SENSE_SELECT) begin
        ext_line_sense_select_next = (pwdata[7:0] & EXT_LINE_SENSE_SELECT_WMASK) | (EXT_LINE_SENSE_SELECT_RST & ~EXT_LINE_SENSE_SELECT_WMASK);
      end
      if (idx == IDX_IER) begin
        ier_next = (pwdata[7:0] & IER_WMASK) | (IER_RST & ~IER_WMASK);
      end
    end
    if (psel && !penable) begin
      err_next = 1'b0;
      unique case (idx)
        IDX_SYSTEM_CONTROL: rdata_next = {24'h000000, system_control_reg};
        IDX_MODE_CONTROL_REG: rdata_next = {24'h000000, MODE_CONTROL_REG_FIXED[7:2], mode_reg};
        IDX_EXT_LINE_SENSE_SELECT: rdata_next = {24'h000000, line_sense_select_reg};
        IDX_IER: rdata_next = {24'h000000, line_enable_reg};
        IDX_STAT: rdata_next = stat_word;
        default: begin
          rdata_next = 32'h0000_0000;
          err_next = 1'b1;
        end
      endcase
      if (paddr[1:0] != 2'b00) begin
        rdata_next = 32'h0000_0000;
        err_next = 1'b1;
      end
    end
    if (!clear_n) begin
      system_control_next = SYSTEM_CONTROL_RST;
      ext_line_sense_select_next = EXT_LINE_SENSE_SELECT_RST;
      ier_next = IER_RST;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_control_reg <= SYSTEM_CONTROL_RST;
      line_sense_select_reg <= EXT_LINE_SENSE_SELECT_RST;
      line_enable_reg <= IER_RST;
      rdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else if (clk_en) begin
      system_control_reg <= system_control_next;
      line_sense_select_reg <= ext_line_sense_select_next;
      line_enable_reg <= ier_next;
      rdata_reg <= rdata_next;
      err_reg <= err_next;
    end
  end

  assign prdata = rdata_reg;
  assign pready = 1'b1;
  assign pslverr = err_reg & psel & penable;

  assign ccr_i_mask = imask_reg;
  // Pin low halts the core in the same cycle
  assign core_hold = in_clear | (st_reg == ST_CLEAR);
  assign periph_init = core_hold | (st_reg == ST_RSTSEQ);
  assign exc_start = start_reg;
  assign exc_is_reset = isrst_reg;
  assign exc_vec_addr = vec_reg;
  assign latched_mode_bit_hi = mode_reg[1];
  assign latched_mode_bit_lo = mode_reg[0];

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_clear_wins: assert property (!clear_n && clk_en |=> st_reg == ST_CLEAR && !start_reg)
    else $error("reset pin did not force reset state");
  a_mode_capture: assert property (st_reg == ST_CLEAR && clear_n && clk_en
    |=> mode_reg == $past({mode_select_pin_hi, mode_select_pin_lo}))
    else $error("mode pins not latched at release");
  a_reset_vector: assert property (st_reg == ST_RSTSEQ && clear_n && clk_en
    |=> start_reg && isrst_reg && vec_reg == 16'h0000 && imask_reg)
    else $error("reset sequence vector or mask wrong");
  a_first_quiet: assert property (st_reg == ST_FIRST && !instr_done && clk_en |=> !start_reg)
    else $error("interrupt accepted before first instruction");
  a_start_cause: assert property (start_reg && !isrst_reg |-> $past(take))
    else $error("sequence started off a boundary");
  a_mask_gate: assert property (take && imask_reg && !nmi_req && !ccr_i_wr && clk_en
    |=> !start_reg)
    else $error("masked interrupt accepted");
  a_accept_mask: assert property (accept && clk_en |=> start_reg ##1 imask_reg || ccr_i_wr)
    else $error("accept did not set mask");
  a_vector_range: assert property (start_reg && !isrst_reg
    |-> vec_reg >= 16'h0006 && vec_reg <= 16'h002E && !vec_reg[0])
    else $error("vector address out of table");
  a_nmi_first: assert property (take && nmi_req && clk_en |=> vec_reg == 16'h0006)
    else $error("nonmaskable interrupt lost priority");
  a_line_disable: assert property (take && !nmi_req && !(|int_req) && line_enable_reg[2:0] == 3'h0
    && clk_en |=> !start_reg)
    else $error("disabled line accepted");

  c_reset_seq: cover property (st_reg == ST_RSTSEQ ##1 st_reg == ST_SEQ);
  c_nmi_take: cover property (accept && win_idx == 5'h00);
  c_line_take: cover property (accept && win_idx == 5'h01);
  c_int_take: cover property (accept && win_idx == 5'h14);
  c_short_rst: cover property ($rose(short_reg));
endmodule

//--- design/rie_pkg.sv
// Constants and types for the reset and interrupt exception controller.
// Assumes a 125 MHz pclk and byte addressing on a 32-bit APB.
package rie_pkg;
  localparam int ADDR_W = 18;
  // Register indexes; byte address is four times the index
  localparam logic [15:0] IDX_SYSTEM_CONTROL = 16'hFFC4;
  localparam logic [15:0] IDX_MODE_CONTROL_REG = 16'hFFC5;
  localparam logic [15:0] IDX_EXT_LINE_SENSE_SELECT = 16'hFFC6;
  localparam logic [15:0] IDX_IER = 16'hFFC7;
  localparam logic [15:0] IDX_STAT = 16'hFFC8;
  localparam logic [7:0] SYSTEM_CONTROL_RST = 8'h0B;
  localparam logic [7:0] SYSTEM_CONTROL_WMASK = 8'hF5;
  localparam int SYSTEM_CONTROL_NONMASKABLE_EDGE_SELECT = 2;
  localparam logic [7:0] EXT_LINE_SENSE_SELECT_RST = 8'h88;
  localparam logic [7:0] EXT_LINE_SENSE_SELECT_WMASK = 8'h77;
  localparam int EXT_LINE_SENSE_SELECT_SC_LSB = 0;
  localparam int EXT_LINE_SENSE_SELECT_EG_LSB = 4;
  localparam logic [7:0] IER_RST = 8'hF8;
  localparam logic [7:0] IER_WMASK = 8'h07;
  localparam logic [7:0] MODE_CONTROL_REG_FIXED = 8'hE4;
  localparam int STAT_SHORT = 0;
  localparam int STAT_IMASK = 1;
  localparam int STAT_INSEQ = 2;
  localparam int STAT_VEC_LSB = 8;
  localparam int NUM_EXT = 3;
  localparam int NUM_INT = 17;
  localparam int NUM_SRC = 21;
  localparam logic [4:0] VEC_NUM_NMI = 5'h03;
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam int RST_MIN_CYC = 10;
  localparam logic [3:0] RST_CNT_MAX = 4'hA;

  typedef enum logic [2:0] {ST_CLEAR, ST_RSTSEQ, ST_SEQ, ST_FIRST, ST_RUN} rie_state_t;

  function automatic logic [15:0] rie_vec_addr(input logic [4:0] num);
    return {10'h000, num, 1'b0};
  endfunction

  function automatic logic [ADDR_W-1:0] rie_byte_addr(input logic [15:0] idx);
    return {idx, 2'b00};
  endfunction
endpackage

//--- design/rie_line_sense.sv
// Sense stage for one active-low interrupt pin: edge latch or level.
// Assumes the pin is already synchronous to pclk.
`timescale 1ns/10ps
module rie_line_sense
  import rie_pkg::*;
(
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset
  input wire logic clk_en, // Freezes state when low
  input wire logic clear, // Chip clear state
  input wire logic pin_n, // Interrupt pin
  input wire logic edge_mode, // 1 edge, 0 low level
  input wire logic rising, // Edge polarity
  input wire logic serve, // Request accepted
  output logic req // Request to arbiter
);
  logic prev_reg, prev_next;
  logic latch_reg, latch_next;
  logic hit;

  always_comb begin
    hit = rising ? (~prev_reg & pin_n) : (prev_reg & ~pin_n);
    prev_next = pin_n;
    // Set wins over the serve clear
    latch_next = (edge_mode & hit) | (latch_reg & ~serve);
    if (clear) begin
      prev_next = 1'b1;
      latch_next = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 1'b1;
      latch_reg <= 1'b0;
    end else if (clk_en) begin
      prev_reg <= prev_next;
      latch_reg <= latch_next;
    end
  end

  // Level requests are never latched
  assign req = edge_mode ? latch_reg : ~pin_n;
endmodule

//--- design/rie_prio.sv
// Fixed-priority pick: lowest index wins.
// Pure logic, no state.
`timescale 1ns/10ps
module rie_prio #(
  parameter int N = 21
) (
  input wire logic [N-1:0] pend, // Eligible requests
  output logic valid, // Any request
  output logic [4:0] index // Winning index
);
  always_comb begin
    valid = 1'b0;
    index = 5'h00;
    for (int i = N - 1; i >= 0; i--) begin
      if (pend[i]) begin
        valid = 1'b1;
        index = 5'(i);
      end
    end
  end
endmodule

//--- tb/rie_core_model.sv
// Behavioural CPU core facing the exception controller.
// Assumes one clock shared with the controller; outputs are one-cycle pulses.
`timescale 1ns/10ps
module rie_core_model (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset
  input wire logic exc_start, // Sequence start pulse
  input wire logic core_hold, // Abandon work
  input wire logic stall, // Holds the current instruction
  input wire logic slow, // Long exception sequence
  output logic instr_done, // Instruction end pulse
  output logic seq_done // Sequence end pulse
);
  logic [3:0] cnt_reg;
  logic busy_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 4'h0;
      busy_reg <= 1'b0;
      instr_done <= 1'b0;
      seq_done <= 1'b0;
    end else begin
      instr_done <= 1'b0;
      seq_done <= 1'b0;
      cnt_reg <= cnt_reg + 4'h1;
      if (core_hold) begin
        busy_reg <= 1'b0;
        cnt_reg <= 4'h0;
      end else if (exc_start) begin
        busy_reg <= 1'b1;
        cnt_reg <= 4'h0;
      end else if (busy_reg) begin
        if (cnt_reg == (slow ? 4'hB : 4'h3)) begin
          seq_done <= 1'b1;
          busy_reg <= 1'b0;
          cnt_reg <= 4'h0;
        end
      end else if (stall) begin
        cnt_reg <= 4'h0;
      end else if (cnt_reg == 4'h3) begin
        instr_done <= 1'b1;
        cnt_reg <= 4'h0;
      end
    end
  end
endmodule

//--- tb/reset_and_interrupt_exception_control_test.sv
// Self-checking bench for the exception controller and its APB registers.
// Assumes the core model above and the package constants of the design.
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module reset_and_interrupt_exception_control_test;
  import rie_pkg::*;
  typedef struct packed {logic wr; logic [15:0] idx; logic [7:0] wd; logic [31:0] exp; logic err;} rie_row_t;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic chip_clear_pin_n, mode_select_pin_hi, mode_select_pin_lo, nmi_pin_n;
  logic [2:0] ext_n;
  logic [NUM_INT-1:0] int_req;
  logic instr_done, seq_done, ccr_i_wr, ccr_i_wdata, ccr_i_mask, core_hold, periph_init;
  logic exc_start, exc_is_reset, latched_mode_bit_hi, latched_mode_bit_lo, stall, slow;
  logic [15:0] exc_vec_addr;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  // Unmapped words sit on both sides of the map
  rie_row_t rows [0:18] = '{
    '{1'b0, IDX_SYSTEM_CONTROL, 8'h00, 32'h0B, 1'b0}, '{1'b0, IDX_EXT_LINE_SENSE_SELECT, 8'h00, 32'h88, 1'b0},
    '{1'b0, IDX_IER, 8'h00, 32'hF8, 1'b0}, '{1'b0, IDX_MODE_CONTROL_REG, 8'h00, 32'hE6, 1'b0},
    '{1'b1, IDX_SYSTEM_CONTROL, 8'h00, 32'h00, 1'b0}, '{1'b0, IDX_SYSTEM_CONTROL, 8'h00, 32'h0A, 1'b0},
    '{1'b1, IDX_SYSTEM_CONTROL, 8'hFF, 32'h00, 1'b0}, '{1'b0, IDX_SYSTEM_CONTROL, 8'h00, 32'hFF, 1'b0},
    '{1'b1, IDX_SYSTEM_CONTROL, 8'h0B, 32'h00, 1'b0}, '{1'b1, IDX_EXT_LINE_SENSE_SELECT, 8'hFF, 32'h00, 1'b0},
    '{1'b0, IDX_EXT_LINE_SENSE_SELECT, 8'h00, 32'hFF, 1'b0}, '{1'b1, IDX_EXT_LINE_SENSE_SELECT, 8'h00, 32'h00, 1'b0},
    '{1'b0, IDX_EXT_LINE_SENSE_SELECT, 8'h00, 32'h88, 1'b0}, '{1'b1, IDX_IER, 8'hFF, 32'h00, 1'b0},
    '{1'b0, IDX_IER, 8'h00, 32'hFF, 1'b0}, '{1'b1, IDX_IER, 8'h00, 32'h00, 1'b0},
    '{1'b0, IDX_IER, 8'h00, 32'hF8, 1'b0}, '{1'b0, 16'hFFC3, 8'h00, 32'h00, 1'b1},
    '{1'b1, 16'hFFC9, 8'h55, 32'h00, 1'b1}};

  rie_exc_ctrl i_rie_exc_ctrl (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .chip_clear_pin_n, .mode_select_pin_hi,
    .mode_select_pin_lo, .nmi_pin_n, .ext_line_0_n(ext_n[0]), .ext_line_1_n(ext_n[1]),
    .ext_line_2_n(ext_n[2]), .int_req, .instr_done, .seq_done, .ccr_i_wr, .ccr_i_wdata,
    .ccr_i_mask, .core_hold, .periph_init, .exc_start, .exc_is_reset, .exc_vec_addr,
    .latched_mode_bit_hi, .latched_mode_bit_lo);
  rie_core_model i_rie_core_model (.pclk, .presetn, .exc_start, .core_hold, .stall, .slow,
    .instr_done, .seq_done);

  initial pclk = 1'b0;
  always #4 pclk = ~pclk;
  // Whole run needs under a thousand cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (n_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic reg_wr(input logic [15:0] idx, input logic [7:0] wd);
    logic [31:0] rd;
    logic e;
    apb(1'b1, idx, wd, rd, e);
  endtask

  task automatic reg_chk(input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    logic e;
    apb(1'b0, idx, 8'h00, rd, e);
    `CHK(rd, exp);
  endtask

  task automatic unmask();
    @(posedge pclk);
    ccr_i_wr <= 1'b1;
    ccr_i_wdata <= 1'b0;
    @(posedge pclk);
    ccr_i_wr <= 1'b0;
  endtask

  task automatic no_start(input int n);
    repeat (n) begin
      @(posedge pclk);
      #1;
      `CHK(exc_start, 1'b0);
    end
  endtask

  task automatic expect_start(input logic [15:0] vec, input logic rst);
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      #1;
      k++;
    end while (exc_start !== 1'b1 && k < 200);
    `CHK(exc_start, 1'b1);
    `CHK(exc_vec_addr, vec);
    `CHK(exc_is_reset, rst);
    `CHK(ccr_i_mask, 1'b1);
  endtask

  task automatic wait_seq();
    do @(posedge pclk); while (seq_done !== 1'b1);
  endtask

  task automatic pin(input int i, input logic v);
    @(posedge pclk);
    ext_n[i] <= v;
  endtask

  initial begin
    logic [31:0] rd;
    logic e;
    {presetn, chip_clear_pin_n, psel, penable, pwrite, ccr_i_wr, ccr_i_wdata} = '0;
    {clk_en, nmi_pin_n, ext_n, mode_select_pin_hi, mode_select_pin_lo} = 7'b1111110;
    {paddr, pwdata, int_req, stall, slow} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    `CHK({core_hold, periph_init, ccr_i_mask}, 3'b111);
    stall <= 1'b1;
    repeat (14) @(posedge pclk); // Power-on hold, far shorter than in silicon
    chip_clear_pin_n <= 1'b1;
    expect_start(VEC_RESET, 1'b1);
    `CHK({latched_mode_bit_hi, latched_mode_bit_lo}, 2'b10);
    wait_seq();
    @(posedge pclk);
    nmi_pin_n <= 1'b0;
    no_start(20);
    stall <= 1'b0;
    expect_start(16'h0006, 1'b0);
    nmi_pin_n <= 1'b1;
    wait_seq();
    foreach (rows[r]) begin
      apb(rows[r].wr, rows[r].idx, rows[r].wd, rd, e);
      `CHK(e, rows[r].err);
      if (!rows[r].wr) `CHK(rd, rows[r].exp);
    end
    // Sense kind per line: low level, falling edge, rising edge
    for (int i = 0; i < 3; i++) begin
      for (int m = 0; m < 3; m++) begin
        reg_wr(IDX_EXT_LINE_SENSE_SELECT, (8'(m != 0) << i) | (8'(m == 2) << (i + 4)));
        reg_wr(IDX_IER, 8'(1 << i));
        unmask();
        pin(i, 1'b0);
        if (m == 1) pin(i, 1'b1);
        if (m == 2) no_start(5);
        if (m == 2) pin(i, 1'b1);
        expect_start(16'(2 * (4 + i)), 1'b0);
        if (m == 0) pin(i, 1'b1);
        wait_seq();
      end
    end
    // Edge caught while the line is disabled
    reg_wr(IDX_EXT_LINE_SENSE_SELECT, 8'h01);
    reg_wr(IDX_IER, 8'h00);
    unmask();
    pin(0, 1'b0);
    pin(0, 1'b1);
    no_start(10);
    reg_wr(IDX_IER, 8'h01);
    expect_start(16'h0008, 1'b0);
    wait_seq();
    // Clock enable low: a write in that time must not land
    @(posedge pclk);
    clk_en <= 1'b0;
    reg_wr(IDX_IER, 8'h06);
    @(posedge pclk);
    clk_en <= 1'b1;
    reg_chk(IDX_IER, 32'hF9);
    @(posedge pclk);
    int_req[5] <= 1'b1;
    no_start(10);
    unmask();
    expect_start(16'h0018, 1'b0);
    wait_seq();
    for (int k = 0; k < NUM_INT; k++) begin
      @(posedge pclk);
      int_req <= {NUM_INT{1'b1}} << k;
      if (k == 0) stall <= 1'b1;
      unmask();
      if (k == 0) no_start(12);
      stall <= 1'b0;
      expect_start(16'(2 * (7 + k)), 1'b0);
      wait_seq();
    end
    // NMI beats a masked line and all flags, then the line beats the flags
    reg_wr(IDX_EXT_LINE_SENSE_SELECT, 8'h00);
    @(posedge pclk);
    int_req <= '1;
    ext_n[0] <= 1'b0;
    nmi_pin_n <= 1'b0;
    slow <= 1'b1;
    expect_start(16'h0006, 1'b0);
    nmi_pin_n <= 1'b1;
    wait_seq();
    unmask();
    expect_start(16'h0008, 1'b0);
    ext_n[0] <= 1'b1;
    wait_seq();
    reg_wr(IDX_SYSTEM_CONTROL, 8'h0F);
    @(posedge pclk);
    int_req <= '0;
    nmi_pin_n <= 1'b0;
    no_start(10);
    nmi_pin_n <= 1'b1;
    expect_start(16'h0006, 1'b0);
    wait_seq();
    // Clear pin in mid-sequence
    @(posedge pclk);
    int_req[0] <= 1'b1;
    unmask();
    expect_start(16'h000E, 1'b0);
    chip_clear_pin_n <= 1'b0;
    {mode_select_pin_hi, mode_select_pin_lo} <= 2'b01;
    #1;
    `CHK({core_hold, periph_init}, 2'b11);
    repeat (10) @(posedge pclk);
    chip_clear_pin_n <= 1'b1;
    int_req <= '0;
    expect_start(VEC_RESET, 1'b1);
    `CHK({latched_mode_bit_hi, latched_mode_bit_lo}, 2'b01);
    wait_seq();
    reg_chk(IDX_SYSTEM_CONTROL, 32'h0B);
    reg_chk(IDX_IER, 32'hF8);
    reg_chk(IDX_MODE_CONTROL_REG, 32'hE5);
    reg_chk(IDX_STAT, 32'h0000_0002);
    // Deliberately short pulse: still a full reset, but flagged
    @(posedge pclk);
    chip_clear_pin_n <= 1'b0;
    repeat (3) @(posedge pclk);
    chip_clear_pin_n <= 1'b1;
    expect_start(VEC_RESET, 1'b1);
    wait_seq();
    reg_chk(IDX_STAT, 32'h0000_0003);
    reg_wr(IDX_STAT, 8'h01);
    reg_chk(IDX_STAT, 32'h0000_0002);
    stop_test();
  end
endmodule
